// *** core/asr_pkg.sv ***
package asr_pkg;

  // register offsets
  localparam logic [8:0] ASR_OFF_PIR = 9'h00C;
  localparam logic [8:0] ASR_OFF_RECEIVE_STATUS_CONTROL = 9'h018;
  localparam logic [8:0] ASR_OFF_RXDATA = 9'h01A;
  localparam logic [8:0] ASR_OFF_PIE = 9'h08C;
  localparam logic [8:0] ASR_OFF_TRANSMIT_STATUS_CONTROL = 9'h098;
  localparam logic [8:0] ASR_OFF_BAUD = 9'h099;

  // receive_status_control fields
  localparam int ASR_RC_SERIAL_PORT_ENABLE = 7;
  localparam int ASR_RC_RX9 = 6;
  localparam int ASR_RC_SREN = 5;
  localparam int ASR_RC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int ASR_RC_FRAMING_ERROR = 2;
  localparam int ASR_RC_OVERRUN_ERROR = 1;
  localparam int ASR_RC_NINTH_RECEIVED_BIT = 0;
  localparam logic [7:0] ASR_RC_WMASK = 8'hF0;

  // interrupt flag / enable fields
  localparam int ASR_PIR_RECEIVE_READY_FLAG = 5;
  localparam int ASR_PIE_RECEIVE_INTERRUPT_ENABLE = 5;

  // transmit_status_control fields
  localparam int ASR_TX_SYNC = 4;
  localparam int ASR_TX_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int ASR_TX_TRMT = 1;

  // reset values
  localparam logic [7:0] ASR_RST_PIR = 8'h00;
  localparam logic [7:0] ASR_RST_RECEIVE_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ASR_RST_PIE = 8'h00;
  localparam logic [7:0] ASR_RST_TRANSMIT_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] ASR_RST_BAUD = 8'h00;

  // timing: sixteen samples per bit, vote on samples 7, 8 and 9
  localparam logic [3:0] ASR_VOTE_A = 4'h7;
  localparam logic [3:0] ASR_VOTE_B = 4'h8;
  localparam logic [3:0] ASR_VOTE_C = 4'h9;
  localparam logic [3:0] ASR_BITS_8 = 4'h8;
  localparam logic [3:0] ASR_BITS_9 = 4'h9;
  localparam logic [1:0] ASR_FIFO_FULL = 2'h2;
  localparam int ASR_FIFO_DEPTH = 2;
  localparam logic [9:0] ASR_LOW_SPEED_MUL = 10'h004;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } asr_bus_req_t;

  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA = 2'b10,
    ASR_STOP = 2'b11
  } asr_rx_state_t;

  typedef struct packed {
    logic framing_error;
    logic d9;
    logic [7:0] data;
  } asr_entry_t;

  typedef struct packed {
    asr_rx_state_t st;
    logic [3:0] samp_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] votes;
    logic [8:0] shift;
    asr_entry_t [ASR_FIFO_DEPTH-1:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    logic overrun;
    logic [7:0] receive_status_control;
    logic [7:0] pir;
    logic [7:0] pie;
    logic [7:0] transmit_status_control;
    logic [7:0] baud;
    logic [7:0] rdata;
  } asr_core_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic [9:0] div_cnt;
    logic tick;
  } asr_front_t;

endpackage : asr_pkg

// *** core/asr_rx_front.sv ***
`timescale 1ns/1ps
module asr_rx_front (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // line and rate
  input wire logic receive_pin_i,
  input wire logic [7:0] baud_divisor_i,
  input wire logic high_speed_baud_select_i,
  // to receiver
  output logic line_o,
  output logic tick_o
);
  import asr_pkg::*;

  asr_front_t front_reg;
  asr_front_t front_next;
  logic [9:0] period;

  always_comb begin
    front_next = front_reg;
    period = {2'b00, baud_divisor_i} + 10'h001;
    if (!high_speed_baud_select_i) begin
      period = 10'(period * ASR_LOW_SPEED_MUL);
    end
    // three-stage synchroniser, level moves once stages two and three agree
    front_next.s1 = receive_pin_i;
    front_next.s2 = front_reg.s1;
    front_next.s3 = front_reg.s2;
    if (front_reg.s2 == front_reg.s3) begin
      front_next.level = front_reg.s3;
    end
    // sixteen-times-bit-rate sample strobe
    front_next.tick = 1'b0;
    if (front_reg.div_cnt >= period - 10'h001) begin
      front_next.div_cnt = 10'h000;
      front_next.tick = 1'b1;
    end else begin
      front_next.div_cnt = front_reg.div_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      front_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, div_cnt: 10'h000, tick: 1'b0};
    end else if (ce_i) begin
      front_reg <= front_next;
    end
  end

  assign line_o = front_reg.level;
  assign tick_o = front_reg.tick & ce_i;

endmodule : asr_rx_front

// *** core/asr_receiver.sv ***
`timescale 1ns/1ps
// Behaviour
// - sample receive line sixteen times per bit
// - receive only while continuous enable is set
// - after stop bit, move byte into FIFO
// - FIFO write sets receive-ready flag
// - interrupt gated by receive interrupt enable
// - ready flag read-only, clears when FIFO empty
// - two-entry FIFO, third byte still shifts
// - full at third stop: overrun, drop byte
// - overrun blocks reception until continuous enable is cleared
// - stop bit zero sets framing error
// - framing and ninth bit stored per entry
// - shared receive pin feeds the sampler
module asr_receiver (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire asr_pkg::asr_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // serial line
  input wire logic receive_pin_i,
  // interrupt
  output logic rx_irq_o
);
  import asr_pkg::*;

  asr_core_t core_reg;
  asr_core_t core_next;
  logic line;
  logic tick;
  logic rx_on;
  logic vote;
  logic pop;
  logic push;
  logic full;
  logic wr_idx;
  logic [3:0] frame_bits;
  asr_entry_t head;
  asr_entry_t new_entry;
  logic [7:0] rd_val;
  logic [7:0] receive_status_control_view;
  logic [7:0] pir_view;
  logic [7:0] transmit_status_control_view;

  asr_rx_front u_front (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .receive_pin_i(receive_pin_i),
    .baud_divisor_i(core_reg.baud),
    .high_speed_baud_select_i(core_reg.transmit_status_control[ASR_TX_HIGH_SPEED_BAUD_SELECT]),
    .line_o(line),
    .tick_o(tick)
  );

  // status views
  always_comb begin
    head = core_reg.fifo[core_reg.rd_ptr];
    if (core_reg.count == 2'h0) begin
      head = '0;
    end
    receive_status_control_view = core_reg.receive_status_control & ASR_RC_WMASK;
    receive_status_control_view[ASR_RC_FRAMING_ERROR] = head.framing_error;
    receive_status_control_view[ASR_RC_OVERRUN_ERROR] = core_reg.overrun;
    receive_status_control_view[ASR_RC_NINTH_RECEIVED_BIT] = head.d9;
    pir_view = core_reg.pir;
    pir_view[ASR_PIR_RECEIVE_READY_FLAG] = (core_reg.count != 2'h0);
    transmit_status_control_view = core_reg.transmit_status_control;
    transmit_status_control_view[ASR_TX_TRMT] = 1'b1;
  end

  always_comb begin
    core_next = core_reg;
    pop = 1'b0;
    push = 1'b0;
    new_entry = '0;
    rd_val = 8'h00;
    vote = 1'b0;
    frame_bits = core_reg.receive_status_control[ASR_RC_RX9] ? ASR_BITS_9 : ASR_BITS_8;

    // register writes
    if (bus_i.we) begin
      case (bus_i.addr)
        ASR_OFF_PIR: begin
          core_next.pir = bus_i.wdata;
          core_next.pir[ASR_PIR_RECEIVE_READY_FLAG] = 1'b0;
        end
        ASR_OFF_RECEIVE_STATUS_CONTROL: core_next.receive_status_control = bus_i.wdata & ASR_RC_WMASK;
        ASR_OFF_PIE: core_next.pie = bus_i.wdata;
        ASR_OFF_TRANSMIT_STATUS_CONTROL: core_next.transmit_status_control = bus_i.wdata;
        ASR_OFF_BAUD: core_next.baud = bus_i.wdata;
        default: ;
      endcase
    end

    // register reads; data register read pops the FIFO
    if (bus_i.re) begin
      case (bus_i.addr)
        ASR_OFF_PIR: rd_val = pir_view;
        ASR_OFF_RECEIVE_STATUS_CONTROL: rd_val = receive_status_control_view;
        ASR_OFF_RXDATA: begin
          rd_val = head.data;
          pop = (core_reg.count != 2'h0);
        end
        ASR_OFF_PIE: rd_val = core_reg.pie;
        ASR_OFF_TRANSMIT_STATUS_CONTROL: rd_val = transmit_status_control_view;
        ASR_OFF_BAUD: rd_val = core_reg.baud;
        default: rd_val = 8'h00;
      endcase
    end
    core_next.rdata = bus_i.re ? rd_val : 8'h00;

    // a pop in the same cycle frees a slot for the arriving byte
    full = (core_reg.count == ASR_FIFO_FULL) && !pop;
    rx_on = core_reg.receive_status_control[ASR_RC_SERIAL_PORT_ENABLE] && core_reg.receive_status_control[ASR_RC_CONTINUOUS_RECEIVE_ENABLE]
            && !core_reg.transmit_status_control[ASR_TX_SYNC];

    // receive engine
    if (!core_reg.receive_status_control[ASR_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
      core_next.overrun = 1'b0;
      core_next.st = ASR_IDLE;
    end else if (!rx_on || core_reg.overrun) begin
      core_next.st = ASR_IDLE;
    end else begin
      if (tick) begin
        core_next.samp_cnt = core_reg.samp_cnt + 4'h1;
        if (core_reg.samp_cnt == ASR_VOTE_A) begin
          core_next.votes[0] = line;
        end
        if (core_reg.samp_cnt == ASR_VOTE_B) begin
          core_next.votes[1] = line;
        end
      end
      vote = (core_reg.votes[0] & core_reg.votes[1]) | (core_reg.votes[0] & line)
             | (core_reg.votes[1] & line);
      case (core_reg.st)
        ASR_IDLE: begin
          core_next.samp_cnt = 4'h0;
          if (!line) begin
            core_next.st = ASR_START;
          end
        end
        ASR_START: begin
          if (tick && core_reg.samp_cnt == ASR_VOTE_C) begin
            if (vote) begin
              core_next.st = ASR_IDLE;
            end else begin
              core_next.st = ASR_DATA;
              core_next.bit_cnt = 4'h0;
            end
          end
        end
        ASR_DATA: begin
          if (tick && core_reg.samp_cnt == ASR_VOTE_C) begin
            core_next.shift = {vote, core_reg.shift[8:1]};
            core_next.bit_cnt = core_reg.bit_cnt + 4'h1;
            if (core_reg.bit_cnt + 4'h1 == frame_bits) begin
              core_next.st = ASR_STOP;
            end
          end
        end
        ASR_STOP: begin
          if (tick && core_reg.samp_cnt == ASR_VOTE_C) begin
            core_next.st = ASR_IDLE;
            new_entry.framing_error = !vote;
            if (core_reg.receive_status_control[ASR_RC_RX9]) begin
              new_entry.d9 = core_reg.shift[8];
              new_entry.data = core_reg.shift[7:0];
            end else begin
              new_entry.d9 = 1'b0;
              new_entry.data = core_reg.shift[8:1];
            end
            if (full) begin
              core_next.overrun = 1'b1;
            end else begin
              push = 1'b1;
            end
          end
        end
        default: core_next.st = ASR_IDLE;
      endcase
    end

    // FIFO pointers; entry written at head plus occupancy
    wr_idx = core_reg.rd_ptr ^ core_reg.count[0];
    for (int i = 0; i < ASR_FIFO_DEPTH; i++) begin
      if (push && wr_idx == 1'(i)) begin
        core_next.fifo[i] = new_entry;
      end
    end
    if (pop) begin
      core_next.rd_ptr = !core_reg.rd_ptr;
    end
    core_next.count = core_reg.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      core_reg <= '{
        st: ASR_IDLE,
        samp_cnt: 4'h0,
        bit_cnt: 4'h0,
        votes: 2'h0,
        shift: 9'h000,
        fifo: '0,
        rd_ptr: 1'b0,
        count: 2'h0,
        overrun: 1'b0,
        receive_status_control: ASR_RST_RECEIVE_STATUS_CONTROL,
        pir: ASR_RST_PIR,
        pie: ASR_RST_PIE,
        transmit_status_control: ASR_RST_TRANSMIT_STATUS_CONTROL,
        baud: ASR_RST_BAUD,
        rdata: 8'h00
      };
    end else if (ce_i) begin
      core_reg <= core_next;
    end
  end

  assign rdata_o = core_reg.rdata;
  assign rx_irq_o = (core_reg.count != 2'h0) && core_reg.pie[ASR_PIE_RECEIVE_INTERRUPT_ENABLE];

endmodule : asr_receiver

// *** verification/asr_receiver_props.sv ***
`timescale 1ns/1ps
module asr_receiver_props
  import asr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire asr_pkg::asr_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  // line and interrupt
  input wire logic receive_pin_i,
  input wire logic rx_irq_o
);
  logic [7:0] pie_reg;
  logic [7:0] rc_reg;
  logic rd_pir;
  logic rd_rc;
  logic rd_dat;
  logic rd_pie;
  assign rd_pir = bus_i.re && bus_i.addr == ASR_OFF_PIR;
  assign rd_rc = bus_i.re && bus_i.addr == ASR_OFF_RECEIVE_STATUS_CONTROL;
  assign rd_dat = bus_i.re && bus_i.addr == ASR_OFF_RXDATA;
  assign rd_pie = bus_i.re && bus_i.addr == ASR_OFF_PIE;
  // shadow copies of software-written enables
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pie_reg <= 8'h00;
      rc_reg <= 8'h00;
    end else if (ce_i && bus_i.we) begin
      if (bus_i.addr == ASR_OFF_PIE) pie_reg <= bus_i.wdata;
      if (bus_i.addr == ASR_OFF_RECEIVE_STATUS_CONTROL) rc_reg <= bus_i.wdata;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  irq_masked_a: assert property (rx_irq_o |-> pie_reg[ASR_PIE_RECEIVE_INTERRUPT_ENABLE])
    else $error("interrupt while masked");
  ready_flag_a: assert property (rd_pir && pie_reg[5] |=> rdata_o[5] == $past(rx_irq_o))
    else $error("ready flag differs from interrupt");
  empty_read_a: assert property (rd_dat && pie_reg[5] && !rx_irq_o |=> rdata_o == 8'h00)
    else $error("empty data read not zero");
  rise_needs_enable_a: assert property ($rose(rx_irq_o) && $stable(pie_reg)
    |-> rc_reg[ASR_RC_CONTINUOUS_RECEIVE_ENABLE] && rc_reg[ASR_RC_SERIAL_PORT_ENABLE])
    else $error("byte received while disabled");
  status_readback_a: assert property (rd_rc |=> rdata_o[7:4] == rc_reg[7:4])
    else $error("control bits read back wrong");
  enable_readback_a: assert property (rd_pie |=> rdata_o == pie_reg)
    else $error("enable register read back wrong");
  flag_fall_a: assert property ($fell(rx_irq_o) |-> $past(rd_dat) || !pie_reg[5])
    else $error("ready flag fell without read");
  empty_status_a: assert property (rd_rc && pie_reg[5] && !rx_irq_o
    |=> rdata_o[2] == 1'b0 && rdata_o[0] == 1'b0)
    else $error("entry status shown with empty queue");
endmodule : asr_receiver_props

bind asr_receiver asr_receiver_props asr_receiver_props_i (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .receive_pin_i(receive_pin_i), .rx_irq_o(rx_irq_o));

// *** verification/asr_serial_tx.sv ***
`timescale 1ns/1ps
module asr_serial_tx #(
  parameter int BIT_CLK = 16
) (
  // clock
  input wire logic clk_sys_i,
  // serial line
  output logic line_o
);
  initial line_o = 1'b1;
  // start low, data lsb first, stop level chosen by caller
  task automatic send(input logic [8:0] data, input int nbits, input logic stp);
    logic [10:0] f;
    f = {1'b1, data, 1'b0};
    f[nbits+1] = stp;
    for (int i = 0; i < nbits + 2; i++) begin
      line_o <= f[i];
      repeat (BIT_CLK) @(posedge clk_sys_i);
    end
    // back to idle for one clock, so a following frame never re-drives the line in this step
    line_o <= 1'b1;
    @(posedge clk_sys_i);
  endtask : send
endmodule : asr_serial_tx

// *** verification/test_asr_receiver.sv ***
`timescale 1ns/1ps
module test_asr_receiver;
  import asr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  asr_bus_req_t bus = '0;
  logic [7:0] rdata;
  logic pin;
  logic irq;
  logic [7:0] q [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  int bad_count = 0;
  int n_tests = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  asr_serial_tx #(.BIT_CLK(16)) asr_serial_tx_i (.clk_sys_i(clk_sys_i), .line_o(pin));
  asr_receiver asr_receiver_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .bus_i(bus), .rdata_o(rdata), .receive_pin_i(pin), .rx_irq_o(irq));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge clk_sys_i);
    bus.we <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clk_sys_i);
    bus.re <= 1'b0;
    #1 chk("register read", rdata, exp);
    @(posedge clk_sys_i);
  endtask : rd
  task automatic give_verdict;
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(ASR_OFF_PIR, 8'h00);
    rd(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h00);
    rd(ASR_OFF_PIE, 8'h00);
    rd(ASR_OFF_TRANSMIT_STATUS_CONTROL, 8'h02);
    rd(ASR_OFF_BAUD, 8'h00);
    rd(9'h1FF, 8'h00);
    // clock enable low: a write must not land
    ce <= 1'b0;
    wr(ASR_OFF_BAUD, 8'h55);
    ce <= 1'b1;
    rd(ASR_OFF_BAUD, 8'h00);
    // fast rate: one tick per clock, sixteen clocks a bit
    wr(ASR_OFF_TRANSMIT_STATUS_CONTROL, 8'h04);
    wr(ASR_OFF_PIE, 8'h20);
    rd(ASR_OFF_PIE, 8'h20);
    wr(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    // plain byte
    asr_serial_tx_i.send(9'h0A5, 8, 1'b1);
    chk("irq", {7'h00, irq}, 8'h01);
    rd(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    rd(ASR_OFF_RXDATA, 8'hA5);
    wr(ASR_OFF_PIR, 8'h20);
    rd(ASR_OFF_PIR, 8'h00);
    // stop bit low
    asr_serial_tx_i.send(9'h03C, 8, 1'b0);
    rd(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h94);
    rd(ASR_OFF_RXDATA, 8'h3C);
    rd(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    // nine-bit frame
    wr(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'hD0);
    asr_serial_tx_i.send(9'h1C3, 9, 1'b1);
    rd(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'hD1);
    rd(ASR_OFF_RXDATA, 8'hC3);
    wr(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    // overrun: third byte lost, fourth refused
    foreach (q[i]) asr_serial_tx_i.send({1'b0, q[i]}, 8, 1'b1);
    rd(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h92);
    rd(ASR_OFF_RXDATA, 8'h11);
    rd(ASR_OFF_RXDATA, 8'h22);
    rd(ASR_OFF_RXDATA, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h80);
    rd(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h80);
    wr(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    asr_serial_tx_i.send(9'h055, 8, 1'b1);
    rd(ASR_OFF_RXDATA, 8'h55);
    // receiver disabled
    wr(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h80);
    asr_serial_tx_i.send(9'h066, 8, 1'b1);
    rd(ASR_OFF_PIR, 8'h00);
    wr(ASR_OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    // masked interrupt, flag still set
    wr(ASR_OFF_PIE, 8'h00);
    asr_serial_tx_i.send(9'h077, 8, 1'b1);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(ASR_OFF_PIR, 8'h20);
    rd(ASR_OFF_RXDATA, 8'h77);
    wr(ASR_OFF_PIE, 8'h20);
    give_verdict();
  end
endmodule : test_asr_receiver
